// ---- design/cswl_chip_select.sv ----
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cswl_chip_select
    import cswl_pkg::*;
#(
    parameter int UNITS = CSWL_UNITS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System bus pins
    input wire logic bus_strobe_n,
    input wire logic bus_read,
    input wire logic [23:0] bus_addr,
    input wire logic [2:0] bus_space_code,
    input wire logic iack_cycle,
    input wire logic locked_write,
    input wire logic ext_master,
    input wire logic internal_access,
    input wire logic cpu_disable_strap,
    // Select lines and acknowledge
    output logic [3:0] select_n,
    input wire logic transfer_acknowledge_n_in,
    output logic transfer_acknowledge_n_out,
    output logic transfer_acknowledge_oe
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [3:0][15:0] base;
        logic [3:0][15:0] option;
        logic [2:0] sysctl;
        logic [1:0] s_strobe;
        logic [1:0] s_read;
        logic [1:0][10:0] s_addr;
        logic [1:0][2:0] s_fc;
        logic [1:0] s_iack;
        logic [1:0] s_lock;
        logic [1:0] s_ext;
        logic [1:0] s_int;
        logic [1:0] s_strap;
        logic [1:0] s_ack;
        logic [1:0] strap_cnt;
        logic strap_done;
        cswl_state_e state;
        logic [2:0] wait_cnt;
        logic [3:0] sel;
        logic ack_gen;
        logic ack_seen;
        logic [31:0] rdata;
    } cswl_state_s;

    cswl_state_s st_reg;
    cswl_state_s st_next;
    logic [3:0] hit;
    logic [1:0] hit_idx;
    logic any_hit;
    logic [2:0] ack_field;
    logic [2:0] waits;
    logic start;
    logic ack_now;
    logic apb_wr;
    logic apb_rd;
    logic mapped;
    logic [2:0] unit_idx;

    // ----------------------------------------
    // Status word layout
    // ----------------------------------------
    localparam int ST_SEL_HI = 3;
    localparam int ST_STATE_HI = 5;
    localparam int ST_STATE_LO = 4;
    localparam int ST_WAIT_HI = 8;
    localparam int ST_WAIT_LO = 6;
    localparam int ST_STRAP_BIT = 9;
    localparam int ST_ACK_BIT = 10;

    // The register map and the status word only have room for four units.
    generate
        if (UNITS != CSWL_UNITS) begin : g_bad_units
            $error("cswl_chip_select supports exactly four select units");
        end
    endgenerate

    // ----------------------------------------
    // Address compare units
    // ----------------------------------------
    generate
        for (genvar u = 0; u < UNITS; u++) begin : g_unit
            cswl_match_unit u_match (
                .base_value(st_reg.base[u]),
                .option_value(st_reg.option[u]),
                .addr_hi(st_reg.s_addr[1]),
                .space_code(st_reg.s_fc[1]),
                .is_read(st_reg.s_read[1]),
                .hit(hit[u])
            );
        end
    endgenerate

    // ----------------------------------------
    // Overlap priority
    // ----------------------------------------
    // Lowest numbered unit wins when ranges overlap.
    always_comb begin
        hit_idx = 2'd0;
        any_hit = 1'b0;
        for (int i = UNITS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = 2'(i);
                any_hit = 1'b1;
            end
        end
    end

    assign ack_field = st_reg.option[hit_idx][CSWL_FC_HI:CSWL_FC_LO];
    assign start = st_reg.s_strobe[1] && (st_reg.state == CSWL_IDLE);

    // ----------------------------------------
    // Wait state selection
    // ----------------------------------------
    // Wait states for the cycle about to start.
    always_comb begin
        waits = ack_field;
        if (st_reg.s_int[1]) begin
            if (!st_reg.sysctl[CSWL_SC_SYNC]) begin
                waits = CSWL_ASYNC_WAITS;
            end else if (st_reg.s_read[1] && st_reg.sysctl[CSWL_SC_EXTERNAL_MASTER_WAIT]) begin
                waits = CSWL_ONE_WAIT;
            end else begin
                waits = CSWL_ZERO_WAITS;
            end
        end else if (st_reg.s_lock[1] && !st_reg.sysctl[CSWL_SC_STRETCH]) begin
            waits = CSWL_ZERO_WAITS;
        end else if (st_reg.s_ext[1] && st_reg.sysctl[CSWL_SC_EXTERNAL_MASTER_WAIT]
                     && ack_field < (CSWL_ACK_EXT - 3'h1)) begin
            waits = ack_field + 3'h1;
        end
    end

    // Acknowledge comes from the wait counter at zero in the count state, field zero included.
    assign ack_now = (st_reg.state == CSWL_COUNT) && st_reg.ack_gen
                     && (st_reg.wait_cnt == CSWL_ZERO_WAITS);

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign unit_idx = paddr[4:2];
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= CSWL_STATUS_OFS);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.s_strobe = {st_reg.s_strobe[0], !bus_strobe_n};
        st_next.s_read = {st_reg.s_read[0], bus_read};
        st_next.s_addr = {st_reg.s_addr[0], bus_addr[23:13]};
        st_next.s_fc = {st_reg.s_fc[0], bus_space_code};
        st_next.s_iack = {st_reg.s_iack[0], iack_cycle};
        st_next.s_lock = {st_reg.s_lock[0], locked_write};
        st_next.s_ext = {st_reg.s_ext[0], ext_master};
        st_next.s_int = {st_reg.s_int[0], internal_access};
        st_next.s_strap = {st_reg.s_strap[0], cpu_disable_strap};
        st_next.s_ack = {st_reg.s_ack[0], !transfer_acknowledge_n_in};

        // ----------------------------------------
        // Strap capture
        // ----------------------------------------
        // Strap is caught once it has crossed both flops after reset release.
        if (!st_reg.strap_done) begin
            if (st_reg.strap_cnt == CSWL_STRAP_DLY) begin
                st_next.strap_done = 1'b1;
                if (st_reg.s_strap[1]) begin
                    st_next.base[0][CSWL_EN_BIT] = 1'b0;
                end
            end else begin
                st_next.strap_cnt = st_reg.strap_cnt + 2'd1;
            end
        end

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        // Registers take writes at any time, enabled or not.
        if (apb_wr && mapped) begin
            if (paddr < CSWL_OPT_OFS) begin
                st_next.base[unit_idx[1:0]] = pwdata[15:0];
            end else if (paddr < CSWL_SYSCTL_OFS) begin
                st_next.option[unit_idx[1:0]] = pwdata[15:0];
            end else if (paddr == CSWL_SYSCTL_OFS) begin
                st_next.sysctl = pwdata[2:0];
            end
        end

        // ----------------------------------------
        // Register reads
        // ----------------------------------------
        // Read data is latched in setup so it stands through the access phase.
        if (apb_rd) begin
            st_next.rdata = '0;
            if (mapped) begin
                if (paddr < CSWL_OPT_OFS) begin
                    st_next.rdata[15:0] = st_reg.base[unit_idx[1:0]];
                end else if (paddr < CSWL_SYSCTL_OFS) begin
                    st_next.rdata[15:0] = st_reg.option[unit_idx[1:0]];
                end else if (paddr == CSWL_SYSCTL_OFS) begin
                    st_next.rdata[2:0] = st_reg.sysctl;
                end else begin
                    st_next.rdata[ST_SEL_HI:0] = st_reg.sel;
                    st_next.rdata[ST_STATE_HI:ST_STATE_LO] = st_reg.state;
                    st_next.rdata[ST_WAIT_HI:ST_WAIT_LO] = st_reg.wait_cnt;
                    st_next.rdata[ST_STRAP_BIT] = st_reg.strap_done;
                    st_next.rdata[ST_ACK_BIT] = st_reg.ack_seen;
                end
            end
        end

        // ----------------------------------------
        // Bus cycle sequencer
        // ----------------------------------------
        // A new cycle is taken only from idle, so strobe must rise in between.
        unique case (st_reg.state)
            CSWL_IDLE: begin
                if (start) begin
                    st_next.ack_seen = 1'b0;
                    if (st_reg.s_iack[1]) begin
                        st_next.sel = '0;
                        st_next.state = CSWL_HOLD;
                    end else if (st_reg.s_int[1]) begin
                        st_next.sel = '0;
                        st_next.ack_gen = 1'b1;
                        st_next.wait_cnt = waits;
                        st_next.state = CSWL_COUNT;
                    end else if (any_hit) begin
                        st_next.sel = 4'b0001 << hit_idx;
                        if (ack_field == CSWL_ACK_EXT) begin
                            st_next.ack_gen = 1'b0;
                            st_next.state = CSWL_EXTERN;
                        end else begin
                            st_next.ack_gen = 1'b1;
                            st_next.wait_cnt = waits;
                            st_next.state = CSWL_COUNT;
                        end
                    end else begin
                        st_next.state = CSWL_HOLD;
                    end
                end
            end
            CSWL_COUNT: begin
                if (st_reg.wait_cnt != CSWL_ZERO_WAITS) begin
                    st_next.wait_cnt = st_reg.wait_cnt - 3'h1;
                end
                if (!st_reg.s_strobe[1]) begin
                    st_next.state = CSWL_IDLE;
                    st_next.sel = '0;
                    st_next.ack_gen = 1'b0;
                end
            end
            CSWL_EXTERN: begin
                if (st_reg.s_ack[1]) begin
                    st_next.ack_seen = 1'b1;
                end
                if (!st_reg.s_strobe[1]) begin
                    st_next.state = CSWL_IDLE;
                    st_next.sel = '0;
                end
            end
            CSWL_HOLD: begin
                if (!st_reg.s_strobe[1]) begin
                    st_next.state = CSWL_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.base[0] <= CSWL_BASE0_RST;
            st_reg.base[1] <= CSWL_BASEN_RST;
            st_reg.base[2] <= CSWL_BASEN_RST;
            st_reg.base[3] <= CSWL_BASEN_RST;
            st_reg.option[0] <= CSWL_OPT_RST;
            st_reg.option[1] <= CSWL_OPT_RST;
            st_reg.option[2] <= CSWL_OPT_RST;
            st_reg.option[3] <= CSWL_OPT_RST;
            st_reg.state <= CSWL_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Zero-wait APB: the answer carries the word latched in setup.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = st_reg.rdata;
    assign select_n = ~st_reg.sel;
    // Pin is driven only while this block owns the acknowledge.
    assign transfer_acknowledge_oe = st_reg.ack_gen && (st_reg.state == CSWL_COUNT);
    assign transfer_acknowledge_n_out = !ack_now;
endmodule : cswl_chip_select
`default_nettype wire

// ---- design/cswl_match_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module cswl_match_unit
    import cswl_pkg::*;
(
    // Unit configuration
    input wire logic [15:0] base_value,
    input wire logic [15:0] option_value,
    // Current bus cycle
    input wire logic [10:0] addr_hi,
    input wire logic [2:0] space_code,
    input wire logic is_read,
    // Result
    output logic hit
);
    logic addr_ok;
    logic dir_ok;
    logic fc_ok;

    // Only unmasked address bits take part in the compare.
    assign addr_ok = ((addr_hi ^ base_value[CSWL_ADR_HI:CSWL_ADR_LO])
                     & option_value[CSWL_ADR_HI:CSWL_ADR_LO]) == '0;
    // Direction compare gives read-only, write-only or both.
    assign dir_ok = !option_value[CSWL_MRW_BIT] || (is_read == base_value[CSWL_RW_BIT]);
    assign fc_ok = !option_value[CSWL_CFC_BIT]
                   || (space_code == base_value[CSWL_FC_HI:CSWL_FC_LO]);
    assign hit = base_value[CSWL_EN_BIT] && addr_ok && dir_ok && fc_ok;
endmodule : cswl_match_unit
`default_nettype wire

// ---- design/cswl_pkg.sv ----
package cswl_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CSWL_BASE_OFS = 8'h00;
    localparam logic [7:0] CSWL_OPT_OFS = 8'h10;
    localparam logic [7:0] CSWL_SYSCTL_OFS = 8'h20;
    localparam logic [7:0] CSWL_STATUS_OFS = 8'h24;
    localparam int CSWL_UNITS = 4;
    localparam int CSWL_REG_W = 16;
    localparam int CSWL_ADDR_W = 11;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CSWL_FC_HI = 15;
    localparam int CSWL_FC_LO = 13;
    localparam int CSWL_ADR_HI = 12;
    localparam int CSWL_ADR_LO = 2;
    localparam int CSWL_RW_BIT = 1;
    localparam int CSWL_EN_BIT = 0;
    localparam int CSWL_MRW_BIT = 1;
    localparam int CSWL_CFC_BIT = 0;
    localparam int CSWL_SC_STRETCH = 0;
    localparam int CSWL_SC_EXTERNAL_MASTER_WAIT = 1;
    localparam int CSWL_SC_SYNC = 2;
    // ----------------------------------------
    // Reset values and wait codes
    // ----------------------------------------
    localparam logic [15:0] CSWL_BASE0_RST = 16'h0001;
    localparam logic [15:0] CSWL_BASEN_RST = 16'h0000;
    localparam logic [15:0] CSWL_OPT_RST = 16'hdffc;
    localparam logic [2:0] CSWL_ACK_EXT = 3'h7;
    localparam logic [2:0] CSWL_ASYNC_WAITS = 3'h3;
    localparam logic [2:0] CSWL_ZERO_WAITS = 3'h0;
    localparam logic [2:0] CSWL_ONE_WAIT = 3'h1;
    localparam logic [1:0] CSWL_STRAP_DLY = 2'h2;

    typedef enum logic [1:0] {
        CSWL_IDLE = 2'b00,
        CSWL_COUNT = 2'b01,
        CSWL_EXTERN = 2'b10,
        CSWL_HOLD = 2'b11
    } cswl_state_e;
endpackage : cswl_pkg

// ---- verif/cswl_chip_select_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module cswl_chip_select_assertions
    import cswl_pkg::*;
#(
    parameter int UNITS = CSWL_UNITS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // System bus
    input wire logic bus_strobe_n,
    input wire logic iack_cycle,
    input wire logic [3:0] select_n,
    input wire logic transfer_acknowledge_n_out,
    input wire logic transfer_acknowledge_oe
);
    // -----------------------------------------------
    // Port relations
    // -----------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_iack_blocked: assert property ((iack_cycle && !bus_strobe_n) [*5] |-> select_n == 4'hf)
        else $error("select asserted in interrupt acknowledge");
    a_one_select: assert property ($countones(~select_n) <= 1)
        else $error("more than one select line low");
    a_select_late: assert property ($fell(bus_strobe_n) && select_n == 4'hf
        |=> select_n == 4'hf ##1 select_n == 4'hf)
        else $error("select earlier than the synchroniser allows");
    a_select_release: assert property ($rose(bus_strobe_n) |-> ##[1:4] select_n == 4'hf)
        else $error("select not released after strobe");
    a_select_holds: assert property (select_n != 4'hf && !bus_strobe_n |=> $stable(select_n))
        else $error("select changed inside a bus cycle");
    a_ack_holds: assert property (transfer_acknowledge_oe && !transfer_acknowledge_n_out
        && !bus_strobe_n |=> !transfer_acknowledge_n_out)
        else $error("acknowledge dropped inside a bus cycle");
    a_oe_in_cycle: assert property (transfer_acknowledge_oe |-> !$past(bus_strobe_n, 1)
        || !$past(bus_strobe_n, 2) || !$past(bus_strobe_n, 3) || !$past(bus_strobe_n, 4))
        else $error("acknowledge driven outside a bus cycle");
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (psel && penable && paddr == 8'h30 |-> pslverr)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (psel && penable && paddr == CSWL_SYSCTL_OFS |-> !pslverr)
        else $error("error on mapped address");
    a_prdata_holds: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data changed outside setup");
    c_select: cover property ($fell(select_n[1]));
    c_ext_ack: cover property (select_n != 4'hf && !transfer_acknowledge_oe [*4]);
    c_slverr: cover property (pslverr);
endmodule : cswl_chip_select_assertions
bind cswl_chip_select cswl_chip_select_assertions #(.UNITS(UNITS)) u_cswl_chip_select_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_strobe_n(bus_strobe_n),
    .iack_cycle(iack_cycle), .select_n(select_n),
    .transfer_acknowledge_n_out(transfer_acknowledge_n_out),
    .transfer_acknowledge_oe(transfer_acknowledge_oe));
`default_nettype wire

// ---- verif/cswl_peripheral_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module cswl_peripheral_model (
    // Clock and select lines
    input wire logic pclk,
    input wire logic [3:0] select_n,
    // Answer control
    input wire logic ext_ack_en,
    input wire logic [3:0] ack_delay,
    // Open-drain acknowledge, pulled up when released
    output logic periph_ack_n
);
    // -----------------------------------------------
    // Slow or prompt peripheral answer
    // -----------------------------------------------
    int cnt;
    initial periph_ack_n = 1'b1;
    // Released line reads high through the pull-up, never a stale low.
    always @(posedge pclk) begin
        if (select_n == 4'hf || !ext_ack_en) begin
            cnt <= 0;
            periph_ack_n <= 1'b1;
        end else begin
            cnt <= cnt + 1;
            if (cnt >= int'(ack_delay)) periph_ack_n <= 1'b0;
        end
    end
endmodule : cswl_peripheral_model
`default_nettype wire

// ---- verif/test_chip_select_wait_state_logic.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_chip_select_wait_state_logic;
    import cswl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_strobe_n, bus_read;
    logic iack_cycle, locked_write, ext_master, internal_access, cpu_disable_strap;
    logic ack_n_out, ack_oe, periph_ack_n, ack_wire, ext_ack_en, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [23:0] bus_addr;
    logic [2:0] bus_space_code;
    logic [3:0] select_n;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Open-drain wire: low when any party pulls it low.
    assign ack_wire = periph_ack_n & (ack_oe ? ack_n_out : 1'b1);
    cswl_chip_select u_cswl_chip_select (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_strobe_n(bus_strobe_n), .bus_read(bus_read),
        .bus_addr(bus_addr), .bus_space_code(bus_space_code), .iack_cycle(iack_cycle),
        .locked_write(locked_write), .ext_master(ext_master), .internal_access(internal_access),
        .cpu_disable_strap(cpu_disable_strap), .select_n(select_n),
        .transfer_acknowledge_n_in(ack_wire), .transfer_acknowledge_n_out(ack_n_out),
        .transfer_acknowledge_oe(ack_oe));
    cswl_peripheral_model u_cswl_peripheral_model (.pclk(pclk), .select_n(select_n),
        .ext_ack_en(ext_ack_en), .ack_delay(4'h3), .periph_ack_n(periph_ack_n));
    // -----------------------------------------------
    // Tasks
    // -----------------------------------------------
    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
            error_cnt++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk("prdata", x, r);
    endtask : rd
    // Expected select line xs (f for none) and device wait count xw (-1 for no device ack).
    task automatic bus(input logic [23:0] a, input logic dr, input logic [2:0] fc,
                       input logic [3:0] xs, input int xw);
        int st;
        int at;
        logic [3:0] sv;
        st = -1;
        at = -1;
        sv = 4'hf;
        bus_addr <= a;
        bus_read <= dr;
        bus_space_code <= fc;
        bus_strobe_n <= 1'b0;
        for (int i = 1; i <= 12; i++) begin
            @(posedge pclk);
            #1;
            if (st < 0 && select_n !== 4'hf) begin
                st = i;
                sv = select_n;
            end
            if (at < 0 && ack_oe === 1'b1 && ack_n_out === 1'b0) at = i;
        end
        @(posedge pclk);
        bus_strobe_n <= 1'b1;
        chk("select_n", 32'(xs), 32'(sv));
        chk("select_edge", (xs == 4'hf) ? -1 : 3, st);
        chk("ack_edge", (xw < 0) ? -1 : 3 + xw, at);
        repeat (5) @(posedge pclk);
        chk("release", 32'h0000_001e, 32'({select_n, ack_oe}));
    endtask : bus
    // -----------------------------------------------
    // Clock, timeout and sequence
    // -----------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // The whole sequence needs about 620 cycles; the ceiling leaves ample margin.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, iack_cycle, locked_write, ext_master} = 7'h00;
        {internal_access, cpu_disable_strap, ext_ack_en, bus_read} = 4'h0;
        {paddr, pwdata, bus_addr, bus_space_code} = 67'h0;
        bus_strobe_n = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            rd(CSWL_BASE_OFS + 8'(4 * i), (i == 0) ? 1 : 0);
            rd(CSWL_OPT_OFS + 8'(4 * i), 32'h0000_dffc);
        end
        rd(8'h30, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, 32'(last_err));
        bus(24'h00_0000, 1'b1, 3'h0, 4'he, 6);
        bus(24'h00_2000, 1'b1, 3'h0, 4'hf, -1);
        iack_cycle <= 1'b1;
        bus(24'h00_0000, 1'b1, 3'h0, 4'hf, -1);
        iack_cycle <= 1'b0;
        wr(CSWL_OPT_OFS + 8'h04, 32'h0000_7ffb);
        wr(CSWL_BASE_OFS + 8'h04, 32'h0000_a203);
        rd(CSWL_BASE_OFS + 8'h04, 32'h0000_a203);
        bus(24'h10_0000, 1'b1, 3'h5, 4'hd, 3);
        bus(24'h10_2000, 1'b1, 3'h5, 4'hd, 3);
        bus(24'h10_4000, 1'b1, 3'h5, 4'hf, -1);
        bus(24'h10_0000, 1'b0, 3'h5, 4'hf, -1);
        bus(24'h10_0000, 1'b1, 3'h1, 4'hf, -1);
        for (int i = 0; i < 7; i++) begin
            wr(CSWL_OPT_OFS + 8'h04, 32'((i << 13) | 16'h1ffb));
            bus(24'h10_0000, 1'b1, 3'h5, 4'hd, i);
        end
        ext_ack_en <= 1'b1;
        wr(CSWL_OPT_OFS + 8'h04, 32'h0000_fffb);
        bus(24'h10_0000, 1'b1, 3'h5, 4'hd, -1);
        rd(CSWL_STATUS_OFS, 32'h0000_0600);
        ext_ack_en <= 1'b0;
        wr(CSWL_OPT_OFS + 8'h08, 32'h0000_9ffe);
        wr(CSWL_BASE_OFS + 8'h08, 32'h0000_0401);
        bus(24'h20_0000, 1'b0, 3'h0, 4'hb, 4);
        bus(24'h20_0000, 1'b1, 3'h0, 4'hf, -1);
        locked_write <= 1'b1;
        bus(24'h20_0000, 1'b0, 3'h0, 4'hb, 0);
        wr(CSWL_SYSCTL_OFS, 32'h0000_0001);
        rd(CSWL_SYSCTL_OFS, 32'h0000_0001);
        chk("pslverr", 32'h0000_0000, 32'(last_err));
        bus(24'h20_0000, 1'b0, 3'h0, 4'hb, 4);
        locked_write <= 1'b0;
        wr(CSWL_BASE_OFS, 32'h0000_0000);
        bus(24'h00_0000, 1'b1, 3'h0, 4'hf, -1);
        wr(CSWL_SYSCTL_OFS, 32'h0000_0002);
        ext_master <= 1'b1;
        bus(24'h20_0000, 1'b0, 3'h0, 4'hb, 5);
        wr(CSWL_SYSCTL_OFS, 32'h0000_0000);
        internal_access <= 1'b1;
        bus(24'h30_0000, 1'b1, 3'h0, 4'hf, 3);
        bus(24'h30_0000, 1'b0, 3'h0, 4'hf, 3);
        wr(CSWL_SYSCTL_OFS, 32'h0000_0006);
        bus(24'h30_0000, 1'b1, 3'h0, 4'hf, 1);
        bus(24'h30_0000, 1'b0, 3'h0, 4'hf, 0);
        wr(CSWL_SYSCTL_OFS, 32'h0000_0004);
        bus(24'h30_0000, 1'b1, 3'h0, 4'hf, 0);
        {ext_master, internal_access} <= 2'b00;
        cpu_disable_strap <= 1'b1;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(CSWL_BASE_OFS, 32'h0000_0000);
        bus(24'h00_0000, 1'b1, 3'h0, 4'hf, -1);
        test_done();
    end
endmodule : test_chip_select_wait_state_logic
`default_nettype wire
